/* logic/scap_pkg.sv */
package scap_pkg;
	// Register window geometry: one 32-bit word per register index.
	localparam int unsigned REG_STRIDE = 4;
	localparam int unsigned IDX_LSB = $clog2(REG_STRIDE);
	localparam int unsigned IDX_W = 9;
	localparam int unsigned CTRL_WIN_LSB = IDX_LSB + IDX_W;
	// Graphics window of 32 Mbyte; the top offset bit picks the aperture.
	localparam int unsigned GFX_WIN_LSB = 25;
	localparam int unsigned APSEL_BIT = 24;
	localparam int unsigned PHYS_W = 26;
	localparam int unsigned START_SHIFT = 11;
	// Register indices of the system control group.
	localparam logic [8:0] IDX_MCMD = 9'h02a;
	localparam logic [8:0] IDX_MSTATE = 9'h02b;
	localparam logic [8:0] IDX_MLOCAL = 9'h02c;
	localparam logic [8:0] IDX_MHOST = 9'h02d;
	localparam logic [8:0] IDX_STATUS = 9'h030;
	localparam logic [8:0] IDX_SCAN = 9'h031;
	localparam logic [8:0] IDX_DEBUG = 9'h032;
	localparam logic [8:0] IDX_PINS = 9'h033;
	localparam logic [8:0] IDX_GPIO = 9'h034;
	localparam logic [8:0] IDX_WIN0 = 9'h036;
	localparam logic [8:0] IDX_WIN1 = 9'h037;
	// Index ranges owned by each unit.
	localparam logic [8:0] PIX_HI = 9'h010;
	localparam logic [8:0] VID_LO = 9'h021;
	localparam logic [8:0] VID_HI = 9'h028;
	localparam logic [8:0] SYS_LO = 9'h02a;
	localparam logic [8:0] SYS_HI = 9'h037;
	localparam logic [8:0] PRIM_LO = 9'h040;
	localparam logic [8:0] PRIM_HI = 9'h074;
	localparam logic [8:0] CODE_LO = 9'h080;
	localparam logic [8:0] CODE_HI = 9'h09f;
	localparam logic [8:0] PAL_LO = 9'h100;
	// Status and compare field positions.
	localparam int unsigned ST_MIRQ = 15;
	localparam int unsigned ST_PIXVIS = 14;
	localparam int unsigned ST_VIRQ = 13;
	localparam int unsigned ST_VCMP = 4;
	localparam int unsigned ST_VY_LSB = 16;
	localparam int unsigned VY_W = 11;
	localparam int unsigned REF_EN = 11;
	localparam int unsigned NFLAG = 3;
	localparam int unsigned MS_STATE_LSB = 24;
	localparam int unsigned MS_CNT_W = 24;
	// Aperture configuration fields.
	localparam int unsigned CFG_MODE = 31;
	localparam int unsigned CFG_PIX = 30;
	localparam int unsigned CFG_SWAP_LSB = 28;
	localparam int unsigned CFG_WIDTH_LSB = 24;
	localparam int unsigned CFG_HEIGHT_LSB = 16;
	localparam int unsigned START_W = 14;
	localparam int unsigned X_BITS_BASE = 5;
	localparam int unsigned LINE_SHIFT = 4;
	localparam logic [2:0] WIDTH_RESERVED = 3'h7;
	localparam logic [31:0] WIN0_MASK = 32'hc73f_3fff;
	localparam logic [31:0] WIN1_MASK = 32'hf73f_3fff;
	localparam logic [31:0] SCAN_MASK = 32'h0000_0fff;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// Unit that owns an addressed register index.
	typedef enum logic [6:0] {
		UNIT_NONE = 7'h01,
		UNIT_PIX = 7'h02,
		UNIT_VID = 7'h04,
		UNIT_SYS = 7'h08,
		UNIT_PRIM = 7'h10,
		UNIT_CODE = 7'h20,
		UNIT_PAL = 7'h40
	} scap_unit_e;
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} scap_reg_req_s;
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} scap_reg_rsp_s;
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
	} scap_mem_req_s;
	typedef struct packed {
		logic ack;
		logic err;
		logic pix32;
		logic [1:0] swap;
		logic [PHYS_W-1:0] phys;
	} scap_mem_rsp_s;
endpackage

/* logic/scap_top.sv */
`timescale 1ns/1ps
module scap_top (
	input wire logic clk, // Bus clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable; freezes all state while low.
	input wire logic [31:0] ctrl_base, // Control register base address.
	input wire logic [31:0] gfx_base, // Graphics memory base address.
	input wire scap_pkg::scap_reg_req_s reg_req, // Register access.
	output scap_pkg::scap_reg_rsp_s reg_rsp, // Register answer.
	output scap_pkg::scap_unit_e reg_unit, // Unit owning the last access.
	input wire scap_pkg::scap_mem_req_s mem_req, // Graphics window access.
	output scap_pkg::scap_mem_rsp_s mem_rsp, // Translated memory address.
	input wire logic master_enable, // Master enable bit.
	input wire logic [7:0] master_state, // Master internal state.
	input wire logic [23:0] master_counter, // Master counter.
	input wire logic master_irq_evt, // Master command interrupt pulse.
	output logic master_run, // Master started.
	output logic [31:0] master_cmd_ptr, // Command pointer.
	output logic [31:0] master_local_addr, // Local memory address.
	output logic [31:0] master_host_addr, // Host memory address.
	input wire logic pixel_visible_evt, // Visible pixel in depth read.
	input wire logic [10:0] video_y, // Current vertical video counter.
	input wire logic [3:0] unit_flags, // Idle and init-done flags.
	output logic [31:0] pin_control, // Pin control register.
	output logic [31:0] gp_pins, // General purpose pin register.
	output logic irq // Interrupt request, active high.
);
	logic ctrl_hit;
	logic wr;
	logic [8:0] idx;
	logic [31:0] status_rd;
	logic [31:0] rd_mux;
	logic [31:0] debug_probe;
	logic [31:0] scan_cmp;
	logic [31:0] win0;
	logic [31:0] win1;
	logic cmp_match;
	logic cmp_prev;
	logic cmp_event;
	logic [2:0] flags;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	logic [2:0] next_flags;
	scap_pkg::scap_unit_e next_unit;

	// Register decode inside the 2048-byte control window.
	assign ctrl_hit = reg_req.valid && (reg_req.addr[31:scap_pkg::CTRL_WIN_LSB]
		== ctrl_base[31:scap_pkg::CTRL_WIN_LSB]);
	assign idx = reg_req.addr[scap_pkg::CTRL_WIN_LSB-1:scap_pkg::IDX_LSB];
	assign wr = ctrl_hit && reg_req.write;

	// Owning unit of the addressed index.
	always_comb begin
		if (idx <= scap_pkg::PIX_HI) begin
			next_unit = scap_pkg::UNIT_PIX;
		end else if (idx >= scap_pkg::VID_LO && idx <= scap_pkg::VID_HI) begin
			next_unit = scap_pkg::UNIT_VID;
		end else if (idx >= scap_pkg::SYS_LO && idx <= scap_pkg::SYS_HI) begin
			next_unit = scap_pkg::UNIT_SYS;
		end else if (idx >= scap_pkg::PRIM_LO && idx <= scap_pkg::PRIM_HI) begin
			next_unit = scap_pkg::UNIT_PRIM;
		end else if (idx >= scap_pkg::CODE_LO && idx <= scap_pkg::CODE_HI) begin
			next_unit = scap_pkg::UNIT_CODE;
		end else if (idx >= scap_pkg::PAL_LO) begin
			next_unit = scap_pkg::UNIT_PAL;
		end else begin
			next_unit = scap_pkg::UNIT_NONE;
		end
	end

	// Master pointer registers and halt or start control.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			master_run <= 1'b0;
			master_cmd_ptr <= scap_pkg::REG_RESET;
			master_local_addr <= scap_pkg::REG_RESET;
			master_host_addr <= scap_pkg::REG_RESET;
		end else if (ce && wr) begin
			if (idx == scap_pkg::IDX_MSTATE) begin
				if (reg_req.wdata == scap_pkg::REG_RESET) begin
					master_run <= 1'b0;
				end else if (master_enable) begin
					master_run <= 1'b1;
				end
			end
			if (idx == scap_pkg::IDX_MCMD) begin
				master_cmd_ptr <= reg_req.wdata;
			end
			if (idx == scap_pkg::IDX_MLOCAL) begin
				master_local_addr <= reg_req.wdata;
			end
			if (idx == scap_pkg::IDX_MHOST) begin
				master_host_addr <= reg_req.wdata;
			end
		end
	end

	// Plain storage registers; scan compare and aperture configs keep only defined fields.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_cmp <= scap_pkg::REG_RESET;
			debug_probe <= scap_pkg::REG_RESET;
			pin_control <= scap_pkg::REG_RESET;
			gp_pins <= scap_pkg::REG_RESET;
			win0 <= scap_pkg::REG_RESET;
			win1 <= scap_pkg::REG_RESET;
		end else if (ce && wr) begin
			case (idx)
				scap_pkg::IDX_SCAN: begin
					scan_cmp <= reg_req.wdata & scap_pkg::SCAN_MASK;
				end
				scap_pkg::IDX_DEBUG: begin
					debug_probe <= reg_req.wdata;
				end
				scap_pkg::IDX_PINS: begin
					pin_control <= reg_req.wdata;
				end
				scap_pkg::IDX_GPIO: begin
					gp_pins <= reg_req.wdata;
				end
				scap_pkg::IDX_WIN0: begin
					win0 <= reg_req.wdata & scap_pkg::WIN0_MASK;
				end
				scap_pkg::IDX_WIN1: begin
					win1 <= reg_req.wdata & scap_pkg::WIN1_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	// Scanline compare fires once when the counter arrives at the reference.
	assign cmp_match = video_y == scan_cmp[scap_pkg::VY_W-1:0];
	assign cmp_event = scan_cmp[scap_pkg::REF_EN] && cmp_match
		&& !cmp_prev;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_prev <= 1'b0;
		end else if (ce) begin
			cmp_prev <= cmp_match;
		end
	end

	// Sticky flags: index 2 master or video compare, 1 visible pixel, 0 video compare.
	assign flag_set = {master_irq_evt || cmp_event, pixel_visible_evt,
		cmp_event};
	assign flag_clr = {3{wr && idx == scap_pkg::IDX_STATUS}} & {
		reg_req.wdata[scap_pkg::ST_MIRQ], reg_req.wdata[scap_pkg::ST_PIXVIS],
		reg_req.wdata[scap_pkg::ST_VIRQ]};
	generate
		for (genvar i = 0; i < scap_pkg::NFLAG; i++) begin : g_flag
			// A set arriving with the clear wins.
			assign next_flags[i] = flag_set[i] || (flags[i] && !flag_clr[i]);
		end
	endgenerate
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			flags <= next_flags;
			irq <= next_flags[2] || next_flags[0];
		end
	end

	// Status word and read multiplexer; unmapped indices read as zero.
	always_comb begin
		status_rd = '0;
		status_rd[scap_pkg::ST_VY_LSB +: scap_pkg::VY_W] = video_y;
		status_rd[scap_pkg::ST_MIRQ] = flags[2];
		status_rd[scap_pkg::ST_PIXVIS] = flags[1];
		status_rd[scap_pkg::ST_VIRQ] = flags[0];
		status_rd[scap_pkg::ST_VCMP] = cmp_match;
		status_rd[3:0] = unit_flags;
		case (idx)
			scap_pkg::IDX_MCMD: rd_mux = master_cmd_ptr;
			scap_pkg::IDX_MSTATE: rd_mux = {master_state,
				master_counter};
			scap_pkg::IDX_MLOCAL: rd_mux = master_local_addr;
			scap_pkg::IDX_MHOST: rd_mux = master_host_addr;
			scap_pkg::IDX_STATUS: rd_mux = status_rd;
			scap_pkg::IDX_SCAN: rd_mux = scan_cmp;
			scap_pkg::IDX_DEBUG: rd_mux = debug_probe;
			scap_pkg::IDX_PINS: rd_mux = pin_control;
			scap_pkg::IDX_GPIO: rd_mux = gp_pins;
			scap_pkg::IDX_WIN0: rd_mux = win0;
			scap_pkg::IDX_WIN1: rd_mux = win1;
			default: rd_mux = '0;
		endcase
	end

	// Register answer one cycle after each accepted access.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rsp <= '0;
			reg_unit <= scap_pkg::UNIT_NONE;
		end else if (ce) begin
			reg_rsp.ack <= ctrl_hit;
			if (ctrl_hit) begin
				reg_unit <= next_unit;
				reg_rsp.rdata <= reg_req.write ? '0 : rd_mux;
			end
		end
	end

	// Aperture translation of a graphics window access.
	logic gfx_hit;
	logic [31:0] cfg;
	logic linear;
	logic [1:0] pshift;
	logic [23:0] pos;
	logic [23:0] pix;
	logic [23:0] ypos;
	logic [10:0] ylimit;
	logic [2:0] wfield;
	logic [scap_pkg::PHYS_W-1:0] base;
	logic [scap_pkg::PHYS_W-1:0] next_phys;
	logic next_err;
	assign gfx_hit = mem_req.valid && (mem_req.addr[31:scap_pkg::GFX_WIN_LSB]
		== gfx_base[31:scap_pkg::GFX_WIN_LSB]);
	assign cfg = mem_req.addr[scap_pkg::APSEL_BIT] ? win1 : win0;
	assign linear = cfg[scap_pkg::CFG_MODE];
	assign pos = mem_req.addr[scap_pkg::APSEL_BIT-1:0];
	assign wfield = cfg[scap_pkg::CFG_WIDTH_LSB +: 3];
	assign base = scap_pkg::PHYS_W'({cfg[scap_pkg::START_W-1:0],
		{scap_pkg::START_SHIFT{1'b0}}});

	// Pixel stride, y coordinate and line bound from the linear fields.
	always_comb begin
		pshift = cfg[scap_pkg::CFG_PIX] ? 2'h2 : 2'h1;
		pix = pos >> pshift;
		ypos = pix >> (scap_pkg::X_BITS_BASE + 32'(wfield));
		// The full six-bit height plus one needs seven bits before scaling.
		ylimit = {7'(cfg[scap_pkg::CFG_HEIGHT_LSB +: 6]) + 7'h01,
			scap_pkg::LINE_SHIFT'(0)};
		if (linear) begin
			next_phys = base + scap_pkg::PHYS_W'(pix << pshift);
			next_err = wfield == scap_pkg::WIDTH_RESERVED
				|| ypos >= 24'(ylimit);
		end else begin
			next_phys = base + scap_pkg::PHYS_W'(pos);
			next_err = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_rsp <= '0;
		end else if (ce) begin
			mem_rsp.ack <= gfx_hit;
			if (gfx_hit) begin
				mem_rsp.phys <= next_phys;
				mem_rsp.err <= next_err;
				mem_rsp.pix32 <= linear && cfg[scap_pkg::CFG_PIX];
				mem_rsp.swap <= mem_req.addr[scap_pkg::APSEL_BIT]
					? cfg[scap_pkg::CFG_SWAP_LSB +: 2] : 2'b00;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_status_clear;
		ce && wr && idx == scap_pkg::IDX_STATUS
			&& reg_req.wdata[scap_pkg::ST_VIRQ] && !cmp_event;
	endsequence
	sequence s_raw_access;
		ce && gfx_hit && !linear;
	endsequence

	AST_IRQ_FOLLOWS: assert property (irq == (flags[2] || flags[0]))
		else $error("irq does not match status bits 15 and 13");
	AST_W1C_VIRQ: assert property (s_status_clear |=> !flags[0])
		else $error("video interrupt flag not cleared by write one");
	AST_SET_WINS: assert property (
		ce && master_irq_evt |=> flags[2] && irq)
		else $error("master interrupt flag lost");
	AST_CMP_SETS: assert property (ce && cmp_event |=> flags[0])
		else $error("scanline compare did not set status bit 13");
	AST_PIX_STICKY: assert property (
		ce && flags[1] && !flag_clr[1] |=> flags[1])
		else $error("visible pixel flag dropped without clear");
	AST_HALT: assert property (ce && wr && idx == scap_pkg::IDX_MSTATE
		&& reg_req.wdata == scap_pkg::REG_RESET |=> !master_run)
		else $error("zero write did not halt master");
	AST_START: assert property (ce && wr && idx == scap_pkg::IDX_MSTATE
		&& reg_req.wdata != scap_pkg::REG_RESET && master_enable
		|=> master_run)
		else $error("nonzero write did not start master");
	AST_RAW_ADDR: assert property (s_raw_access |=> mem_rsp.ack
		&& mem_rsp.phys == $past(base) + scap_pkg::PHYS_W'($past(pos))
		&& !mem_rsp.err && !mem_rsp.pix32)
		else $error("raw aperture address wrong");
	AST_RESERVED_W: assert property (ce && gfx_hit && linear
		&& wfield == scap_pkg::WIDTH_RESERVED |=> mem_rsp.err)
		else $error("reserved width not flagged");
	AST_UNIT_SYS: assert property (ce && ctrl_hit
		&& idx == scap_pkg::IDX_STATUS |=> reg_unit == scap_pkg::UNIT_SYS
		&& reg_rsp.ack)
		else $error("system control index misrouted");

	// Answers, flag sets and clears, refused master starts and aperture fields seen one cycle on.
	sequence s_master_clear;
		ce && wr && idx == scap_pkg::IDX_STATUS
			&& reg_req.wdata[scap_pkg::ST_MIRQ]
			&& !master_irq_evt && !cmp_event;
	endsequence
	AST_W1C_MIRQ: assert property (s_master_clear |=> !flags[2])
		else $error("master interrupt flag not cleared by write one");
	AST_REG_ACK: assert property (
		ce |=> reg_rsp.ack == $past(ctrl_hit))
		else $error("register answer not one cycle after the access");
	AST_MEM_ACK: assert property (
		ce |=> mem_rsp.ack == $past(gfx_hit))
		else $error("window answer not one cycle after the access");
	AST_PIX_SETS: assert property (
		ce && pixel_visible_evt |=> flags[1])
		else $error("visible pixel event did not set status bit 14");
	AST_NO_ENABLE: assert property (
		ce && wr && idx == scap_pkg::IDX_MSTATE && !master_enable
		&& reg_req.wdata != scap_pkg::REG_RESET |=> $stable(master_run))
		else $error("master started without enable");
	AST_SWAP0: assert property (
		ce && gfx_hit && !mem_req.addr[scap_pkg::APSEL_BIT]
		|=> mem_rsp.swap == 2'b00)
		else $error("aperture 0 access carries a data swap");
	AST_PIX32: assert property (
		ce && gfx_hit && linear
		|=> mem_rsp.pix32 == $past(cfg[scap_pkg::CFG_PIX]))
		else $error("pixel size flag does not follow the aperture");
endmodule

/* testbench/scap_far_model.sv */
`timescale 1ns/1ps
module scap_far_model #(
	parameter logic [10:0] START_Y = 11'h003
) (
	input wire logic clk, // Bus clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic video_go, // Lets the line counter advance.
	input wire logic master_run, // Master running level.
	output logic [10:0] video_y, // Vertical line counter.
	output logic [7:0] master_state, // Master internal state.
	output logic [23:0] master_counter // Master progress counter.
);
	// The line counter stands still unless the bench lets it run.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			video_y <= START_Y;
		end else if (video_go) begin
			video_y <= video_y + 11'h001;
		end
	end
	// Work done by the master only advances while it has been started.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			master_counter <= 24'h00_0000;
		end else if (master_run) begin
			master_counter <= master_counter + 24'h00_0001;
		end
	end
	// The state code tells a running master from a halted one.
	assign master_state = master_run ? 8'h81 : 8'h00;
endmodule

/* testbench/test_system_control_and_apertures.sv */
`timescale 1ns/1ps
module test_system_control_and_apertures;
	localparam logic [31:0] CB = 32'h0001_0000;
	localparam logic [31:0] GB = 32'h0400_0000;
	localparam logic [3:0] FLAGS = 4'ha;
	localparam logic [10:0] Y0 = 11'h003;
	localparam logic [8:0] RW [6] = '{9'h02a, 9'h02c, 9'h02d, 9'h032,
		9'h033, 9'h034};
	localparam int UI [17] = '{0, 16, 17, 33, 40, 41, 42, 55, 56, 64, 116,
		117, 128, 159, 160, 256, 511};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic master_enable = 1'b0;
	logic master_irq_evt = 1'b0;
	logic pixel_visible_evt = 1'b0;
	logic video_go = 1'b0;
	scap_pkg::scap_reg_req_s reg_req = '0;
	scap_pkg::scap_reg_rsp_s reg_rsp;
	scap_pkg::scap_unit_e reg_unit;
	scap_pkg::scap_mem_req_s mem_req = '0;
	scap_pkg::scap_mem_rsp_s mem_rsp;
	logic master_run, irq;
	logic [7:0] master_state;
	logic [23:0] master_counter;
	logic [10:0] video_y;
	logic [31:0] master_cmd_ptr, master_local_addr, master_host_addr;
	logic [31:0] pin_control, gp_pins;
	int mismatches = 0;
	int checks = 0;

	// The bus clock, 100 ns period.
	always #50 clk = ~clk;

	scap_top u_scap_top (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.ctrl_base(CB), .gfx_base(GB), .reg_req(reg_req), .reg_rsp(reg_rsp),
		.reg_unit(reg_unit), .mem_req(mem_req), .mem_rsp(mem_rsp),
		.master_enable(master_enable), .master_state(master_state),
		.master_counter(master_counter), .master_irq_evt(master_irq_evt),
		.master_run(master_run), .master_cmd_ptr(master_cmd_ptr),
		.master_local_addr(master_local_addr),
		.master_host_addr(master_host_addr),
		.pixel_visible_evt(pixel_visible_evt), .video_y(video_y),
		.unit_flags(FLAGS), .pin_control(pin_control), .gp_pins(gp_pins),
		.irq(irq));
	scap_far_model #(.START_Y(Y0)) u_scap_far_model (.clk(clk),
		.rst_n(rst_n), .video_go(video_go), .master_run(master_run),
		.video_y(video_y), .master_state(master_state),
		.master_counter(master_counter));

	// Compares one result and reports a difference at once.
	task cmp(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One register cycle: request for one edge, answer one cycle later.
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic ok, output logic [31:0] q);
		@(posedge clk);
		reg_req <= {1'b1, w, a, d};
		@(posedge clk);
		reg_req.valid <= 1'b0;
		#1;
		cmp(reg_rsp.ack, ok);
		q = reg_rsp.rdata;
	endtask

	task wr(input logic [8:0] i, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, CB | {21'h0, i, 2'b00}, d, 1'b1, q);
	endtask

	task rd(input logic [8:0] i, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, CB | {21'h0, i, 2'b00}, 32'h0000_0000, 1'b1, q);
		cmp(q, e);
	endtask

	// One window access; a refused one only checks for the missing ack.
	task mem(input logic [31:0] a, input logic [30:0] e);
		@(posedge clk);
		mem_req <= {1'b1, a};
		@(posedge clk);
		mem_req.valid <= 1'b0;
		#1;
		if (e[30]) begin
			cmp(mem_rsp, e);
		end else begin
			cmp(mem_rsp.ack, 1'b0);
		end
	endtask

	// Status word built from flag bits 15..13, line and live compare.
	function logic [31:0] st(input logic [2:0] f, input logic [10:0] y,
		input logic m);
		return {5'h00, y, f, 8'h00, m, FLAGS};
	endfunction

	function logic [6:0] unit_of(input int i);
		if (i <= 16) return 7'h02;
		if (i >= 33 && i <= 40) return 7'h04;
		if (i >= 42 && i <= 55) return 7'h08;
		if (i >= 64 && i <= 116) return 7'h10;
		if (i >= 128 && i <= 159) return 7'h20;
		if (i >= 256) return 7'h40;
		return 7'h01;
	endfunction

	// Prints the counts and the verdict, then ends the run.
	task results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Cuts a hung run short.
	initial begin
		#3_000_000;
		mismatches++;
		results;
	end

	// Main sequence of register and window accesses.
	initial begin
		logic [31:0] q;
		repeat (10) @(posedge clk);
		cmp({reg_unit, irq, master_run}, {7'h01, 2'b00});
		rst_n <= 1'b1;
		rd(scap_pkg::IDX_STATUS, st(3'b000, Y0, 1'b0));
		cmp(reg_unit, 7'h08);
		for (int k = 0; k < 6; k++) wr(RW[k], 32'h5a00_0000 | RW[k]);
		for (int k = 0; k < 6; k++) rd(RW[k], 32'h5a00_0000 | RW[k]);
		cmp(master_cmd_ptr, 32'h5a00_002a);
		cmp({master_local_addr, master_host_addr}, 64'h5a00_002c_5a00_002d);
		cmp({pin_control, gp_pins}, 64'h5a00_0033_5a00_0034);
		wr(scap_pkg::IDX_WIN0, 32'hffff_ffff);
		rd(scap_pkg::IDX_WIN0, 32'hc73f_3fff);
		wr(scap_pkg::IDX_WIN1, 32'hffff_ffff);
		rd(scap_pkg::IDX_WIN1, 32'hf73f_3fff);
		wr(scap_pkg::IDX_SCAN, 32'hffff_f000);
		rd(scap_pkg::IDX_SCAN, 32'h0000_0000);
		rd(9'h02e, 32'h0000_0000);
		for (int k = 0; k < 17; k++) begin
			bus(1'b0, CB | 32'(UI[k] * 4), 32'h0000_0000, 1'b1, q);
			cmp(reg_unit, unit_of(UI[k]));
		end
		bus(1'b1, 32'h0002_00cc, 32'hffff_ffff, 1'b0, q);
		cmp(pin_control, 32'h5a00_0033);
		// Start refused without enable, then start and halt.
		wr(scap_pkg::IDX_MSTATE, 32'h0000_0001);
		cmp(master_run, 1'b0);
		@(posedge clk);
		master_enable <= 1'b1;
		wr(scap_pkg::IDX_MSTATE, 32'h8000_0000);
		cmp(master_run, 1'b1);
		// Running: state code 81, one count since the start edge.
		rd(scap_pkg::IDX_MSTATE, 32'h8100_0001);
		repeat (5) @(posedge clk);
		wr(scap_pkg::IDX_MSTATE, 32'h0000_0000);
		cmp(master_run, 1'b0);
		// Halted after nine counted edges, state code back to zero.
		rd(scap_pkg::IDX_MSTATE, 32'h0000_0009);
		// Sticky flags and their write-one clears.
		@(posedge clk);
		master_irq_evt <= 1'b1;
		@(posedge clk);
		master_irq_evt <= 1'b0;
		rd(scap_pkg::IDX_STATUS, st(3'b100, Y0, 1'b0));
		cmp(irq, 1'b1);
		wr(scap_pkg::IDX_STATUS, 32'h0000_8000);
		rd(scap_pkg::IDX_STATUS, st(3'b000, Y0, 1'b0));
		cmp(irq, 1'b0);
		@(posedge clk);
		pixel_visible_evt <= 1'b1;
		@(posedge clk);
		pixel_visible_evt <= 1'b0;
		rd(scap_pkg::IDX_STATUS, st(3'b010, Y0, 1'b0));
		cmp(irq, 1'b0);
		wr(scap_pkg::IDX_STATUS, 32'h0000_4000);
		rd(scap_pkg::IDX_STATUS, st(3'b000, Y0, 1'b0));
		// Line passes reference 5 with compare off, then 10 with it on.
		wr(scap_pkg::IDX_SCAN, 32'h0000_0005);
		@(posedge clk);
		video_go <= 1'b1;
		repeat (4) @(posedge clk);
		video_go <= 1'b0;
		rd(scap_pkg::IDX_STATUS, st(3'b000, 11'h007, 1'b0));
		wr(scap_pkg::IDX_SCAN, 32'h0000_080a);
		@(posedge clk);
		video_go <= 1'b1;
		repeat (5) @(posedge clk);
		video_go <= 1'b0;
		rd(scap_pkg::IDX_STATUS, st(3'b101, 11'h00c, 1'b0));
		cmp(irq, 1'b1);
		wr(scap_pkg::IDX_STATUS, 32'h0000_2000);
		rd(scap_pkg::IDX_STATUS, st(3'b100, 11'h00c, 1'b0));
		cmp(irq, 1'b1);
		wr(scap_pkg::IDX_STATUS, 32'h0000_8000);
		cmp(irq, 1'b0);
		// Reference on the current line with compare off: live bit only.
		wr(scap_pkg::IDX_SCAN, 32'h0000_000c);
		rd(scap_pkg::IDX_STATUS, st(3'b000, 11'h00c, 1'b1));
		// Raw aperture 0 with linear-only fields set, then linear aperture 1.
		wr(scap_pkg::IDX_WIN0, 32'h4700_0003);
		mem(GB | 32'h0012_3456, {3'b100, 2'b00, 26'h012_4c56});
		wr(scap_pkg::IDX_WIN1, 32'he100_0002);
		mem(GB | 32'h0100_0107, {3'b101, 2'b10, 26'h000_1104});
		mem(GB | 32'h0101_0007, {3'b111, 2'b10, 26'h001_1004});
		mem(GB | 32'h0012_3456, {3'b100, 2'b00, 26'h012_4c56});
		// Height 32 allows 528 lines, so line 256 is in range.
		wr(scap_pkg::IDX_WIN1, 32'he120_0002);
		mem(GB | 32'h0101_0007, {3'b101, 2'b10, 26'h001_1004});
		wr(scap_pkg::IDX_WIN1, 32'he700_0002);
		mem(GB | 32'h0100_0107, {3'b111, 2'b10, 26'h000_1104});
		mem(32'h0812_3456, 31'h0000_0000);
		results;
	end
endmodule
